// *** design/scx_exec.sv ***
// Purpose: Execute stage for system-control instructions of the core
// Assumes: One instruction offered per cycle, held while busy is high
// Notes:   Outputs are registered; exception entry is done by the caller
`timescale 1ns/1ps
`default_nettype none

module scx_exec (
	input  wire  logic                  clk,
	input  wire  logic                  rst,
	input  wire  scx_pkg::scx_instr_s   instr,
	input  wire  logic                  privileged,
	input  wire  logic                  mem_outstanding,
	input  wire  logic                  debugger_attached,
	input  wire  logic                  brk_lockup_sel,
	input  wire  logic                  call_prio_blocked,
	input  wire  logic                  sev_on_pend,
	input  wire  logic                  irq_request,
	input  wire  scx_pkg::scx_wake_s    wake_src,
	input  wire  logic [31:0]           ipsr_epsr,
	output logic                        busy,
	output logic                        flush,
	output logic                        event_out,
	output logic                        call_req,
	output logic                        fault_req,
	output logic                        debug_halt,
	output logic                        lockup,
	output logic                        sleeping,
	output logic                        irq_take,
	output logic                        irq_mask,
	output logic [3:0]                  flags,
	output logic [1:0]                  control,
	output logic [7:0]                  imm_seen,
	output scx_pkg::scx_wb_s            wb
);

	// ****************************************************************
	// State
	// ****************************************************************
	scx_pkg::scx_state_s st;
	scx_pkg::scx_state_s next_st;
	logic                wake;
	logic                take;
	logic                next_irq_take;
	logic                irq_take_q;
	logic [31:0]         rd_val;

	scx_wake u_wake (
		.src         (wake_src),
		.for_irq     (st.sleep_irq),
		.sev_on_pend (sev_on_pend),
		.wake        (wake)
	);

	assign take = instr.valid && st.state == scx_pkg::SCX_ST_RUN;

	// ****************************************************************
	// Special register read mux
	// ****************************************************************
	always_comb begin
		rd_val = scx_pkg::WORD_ZERO;
		unique case (instr.sreg_sel)
			scx_pkg::SREG_APP_STATUS: begin
				rd_val[scx_pkg::FLAGS_MSB:scx_pkg::FLAGS_LSB] = st.flags;
			end
			scx_pkg::SREG_IAPSR, scx_pkg::SREG_EAPSR,
			scx_pkg::SREG_XPSR: begin
				rd_val = ipsr_epsr;
				rd_val[scx_pkg::FLAGS_MSB:scx_pkg::FLAGS_LSB] = st.flags;
			end
			scx_pkg::SREG_IPSR, scx_pkg::SREG_EPSR,
			scx_pkg::SREG_IEPSR: begin
				rd_val = ipsr_epsr;
			end
			scx_pkg::SREG_MSP: begin
				rd_val = st.msp;
			end
			scx_pkg::SREG_PSP: begin
				rd_val = st.psp;
			end
			scx_pkg::SREG_IRQ_MASK: begin
				rd_val[0] = st.irq_mask;
			end
			scx_pkg::SREG_CONTROL: begin
				rd_val[1:0] = st.control;
			end
			default: begin
				rd_val = scx_pkg::WORD_ZERO;
			end
		endcase
		// Status-only view when unprivileged
		if (!privileged) begin
			rd_val = scx_pkg::WORD_ZERO;
			if (instr.sreg_sel == scx_pkg::SREG_APP_STATUS) begin
				rd_val[scx_pkg::FLAGS_MSB:scx_pkg::FLAGS_LSB] = st.flags;
			end
		end
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st            = st;
		next_st.wb.valid   = 1'b0;
		next_st.flush      = 1'b0;
		next_st.event_out  = 1'b0;
		next_st.call_req   = 1'b0;
		next_st.fault_req  = 1'b0;
		// Mask gates all but NMI
		next_irq_take = (irq_request && !st.irq_mask) ||
			wake_src.nmi_pending;

		unique case (st.state)
			scx_pkg::SCX_ST_RUN: begin
				if (take) begin
					unique case (instr.op)
						scx_pkg::SCX_OP_BREAKPOINT: begin
							next_st.imm_seen = instr.imm;
							if (debugger_attached) begin
								next_st.state      = scx_pkg::SCX_ST_HALT;
								next_st.debug_halt = 1'b1;
							end else if (brk_lockup_sel) begin
								next_st.state  = scx_pkg::SCX_ST_HALT;
								next_st.lockup = 1'b1;
							end else begin
								next_st.fault_req = 1'b1;
							end
						end
						scx_pkg::SCX_OP_MASK_SET: begin
							if (privileged) begin
								next_st.irq_mask = 1'b1;
							end
						end
						scx_pkg::SCX_OP_MASK_CLEAR: begin
							if (privileged) begin
								next_st.irq_mask = 1'b0;
							end
						end
						scx_pkg::SCX_OP_MEM_BAR, scx_pkg::SCX_OP_SYNC_BAR: begin
							// One-core pipeline: ordering via full drain
							if (mem_outstanding) begin
								next_st.state = scx_pkg::SCX_ST_DRAIN;
								next_st.busy  = 1'b1;
							end
						end
						scx_pkg::SCX_OP_INSTR_BAR: begin
							next_st.flush = 1'b1;
						end
						scx_pkg::SCX_OP_SREG_READ: begin
							next_st.wb.valid = 1'b1;
							next_st.wb.dst   = instr.dst;
							next_st.wb.data  = rd_val;
						end
						scx_pkg::SCX_OP_SREG_WRITE: begin
							unique case (instr.sreg_sel)
								scx_pkg::SREG_APP_STATUS, scx_pkg::SREG_IAPSR,
								scx_pkg::SREG_EAPSR, scx_pkg::SREG_XPSR: begin
									next_st.flags = instr.src[scx_pkg::FLAGS_MSB:
										scx_pkg::FLAGS_LSB];
								end
								scx_pkg::SREG_MSP: begin
									if (privileged) begin
										next_st.msp = instr.src;
									end
								end
								scx_pkg::SREG_PSP: begin
									if (privileged) begin
										next_st.psp = instr.src;
									end
								end
								scx_pkg::SREG_IRQ_MASK: begin
									if (privileged) begin
										next_st.irq_mask = instr.src[0];
									end
								end
								scx_pkg::SREG_CONTROL: begin
									if (privileged) begin
										next_st.control = instr.src[1:0];
									end
								end
								default: begin
									next_st.flags = st.flags;
								end
							endcase
						end
						scx_pkg::SCX_OP_SEND_EVT: begin
							next_st.event_out = 1'b1;
							next_st.event_reg = 1'b1;
						end
						scx_pkg::SCX_OP_SUP_CALL: begin
							next_st.imm_seen = instr.imm;
							if (call_prio_blocked) begin
								next_st.fault_req = 1'b1;
							end else begin
								next_st.call_req = 1'b1;
							end
						end
						scx_pkg::SCX_OP_WAIT_EVT: begin
							if (st.event_reg) begin
								next_st.event_reg = 1'b0;
							end else begin
								next_st.state     = scx_pkg::SCX_ST_SLEEP;
								next_st.sleep_irq = 1'b0;
								next_st.busy      = 1'b1;
								next_st.sleeping  = 1'b1;
							end
						end
						scx_pkg::SCX_OP_WAIT_IRQ: begin
							next_st.state     = scx_pkg::SCX_ST_SLEEP;
							next_st.sleep_irq = 1'b1;
							next_st.busy      = 1'b1;
							next_st.sleeping  = 1'b1;
						end
						default: begin
							// No-operation retires in the take cycle
							next_st.busy = 1'b0;
						end
					endcase
				end
			end
			scx_pkg::SCX_ST_DRAIN: begin
				// Later instructions stall on busy until drained
				if (!mem_outstanding) begin
					next_st.state = scx_pkg::SCX_ST_RUN;
					next_st.busy  = 1'b0;
				end
			end
			scx_pkg::SCX_ST_SLEEP: begin
				// A wait is only a hint; any wake ends it early
				if (wake) begin
					next_st.state    = scx_pkg::SCX_ST_RUN;
					next_st.busy     = 1'b0;
					next_st.sleeping = 1'b0;
				end
			end
			scx_pkg::SCX_ST_HALT: begin
				// Left only by reset; debugger restart is outside this block
				next_st.busy = 1'b1;
			end
		endcase

		// An external event arriving while not in the sleep state is remembered
		if (wake_src.ext_event && st.state != scx_pkg::SCX_ST_SLEEP) begin
			next_st.event_reg = 1'b1;
		end
		if (st.state == scx_pkg::SCX_ST_RUN && take &&
			instr.op == scx_pkg::SCX_OP_BREAKPOINT &&
			(debugger_attached || brk_lockup_sel)) begin
			next_st.busy = 1'b1;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			st            <= '0;
			st.state      <= scx_pkg::SCX_ST_RUN;
			st.event_reg  <= scx_pkg::EVENT_RST;
			st.irq_mask   <= scx_pkg::MASK_RST;
			st.flags      <= scx_pkg::FLAGS_RST;
			st.control    <= scx_pkg::CTRL_RST;
			irq_take_q    <= 1'b0;
		end else begin
			st            <= next_st;
			irq_take_q    <= next_irq_take;
		end
	end

	assign busy       = st.busy;
	assign flush      = st.flush;
	assign event_out  = st.event_out;
	assign call_req   = st.call_req;
	assign fault_req  = st.fault_req;
	assign debug_halt = st.debug_halt;
	assign lockup     = st.lockup;
	assign sleeping   = st.sleeping;
	assign irq_take   = irq_take_q;
	assign irq_mask   = st.irq_mask;
	assign flags      = st.flags;
	assign control    = st.control;
	assign imm_seen   = st.imm_seen;
	assign wb         = st.wb;

endmodule // scx_exec
`default_nettype wire

// *** design/scx_pkg.sv ***
// Purpose: Shared types and constants for the system-control execute unit
// Assumes: Single 100 MHz clock, synchronous active-high reset
// Notes:   Opcode codes below are internal to the core, not an encoding
package scx_pkg;

	localparam int unsigned CLK_PERIOD_NS = 10;

	typedef enum logic [3:0] {
		SCX_OP_NONE,
		SCX_OP_BREAKPOINT,
		SCX_OP_MASK_SET,
		SCX_OP_MASK_CLEAR,
		SCX_OP_MEM_BAR,
		SCX_OP_SYNC_BAR,
		SCX_OP_INSTR_BAR,
		SCX_OP_SREG_READ,
		SCX_OP_SREG_WRITE,
		SCX_OP_IDLE,
		SCX_OP_SEND_EVT,
		SCX_OP_SUP_CALL,
		SCX_OP_WAIT_EVT,
		SCX_OP_WAIT_IRQ
	} scx_op_e;

	// Special register selectors
	localparam logic [7:0] SREG_APP_STATUS = 8'h00;
	localparam logic [7:0] SREG_IAPSR   = 8'h01;
	localparam logic [7:0] SREG_EAPSR   = 8'h02;
	localparam logic [7:0] SREG_XPSR    = 8'h03;
	localparam logic [7:0] SREG_IPSR    = 8'h05;
	localparam logic [7:0] SREG_EPSR    = 8'h06;
	localparam logic [7:0] SREG_IEPSR   = 8'h07;
	localparam logic [7:0] SREG_MSP     = 8'h08;
	localparam logic [7:0] SREG_PSP     = 8'h09;
	localparam logic [7:0] SREG_IRQ_MASK = 8'h10;
	localparam logic [7:0] SREG_CONTROL = 8'h14;

	localparam int unsigned FLAGS_MSB = 31;
	localparam int unsigned FLAGS_LSB = 28;
	localparam logic [3:0]  FLAGS_RST = 4'h0;
	localparam logic        EVENT_RST = 1'b0;
	localparam logic        MASK_RST  = 1'b0;
	localparam logic [1:0]  CTRL_RST  = 2'h0;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic       valid;
		scx_op_e    op;
		logic [7:0] imm;
		logic [7:0] sreg_sel;
		logic [31:0] src;
		logic [3:0] dst;
	} scx_instr_s;

	typedef struct packed {
		logic       nmi_pending;
		logic       exc_take;
		logic       irq_pending_any;
		logic       exc_pending_new;
		logic       dbg_request;
		logic       dbg_enabled;
		logic       ext_event;
	} scx_wake_s;

	typedef struct packed {
		logic       valid;
		logic [3:0] dst;
		logic [31:0] data;
	} scx_wb_s;

	typedef enum logic [1:0] {
		SCX_ST_RUN,
		SCX_ST_DRAIN,
		SCX_ST_SLEEP,
		SCX_ST_HALT
	} scx_state_e;

	typedef struct packed {
		scx_state_e  state;
		logic        sleep_irq;
		logic        event_reg;
		logic        irq_mask;
		logic [3:0]  flags;
		logic [1:0]  control;
		logic [31:0] msp;
		logic [31:0] psp;
		scx_wb_s     wb;
		logic        busy;
		logic        flush;
		logic        event_out;
		logic        call_req;
		logic        fault_req;
		logic        debug_halt;
		logic        lockup;
		logic        sleeping;
		logic [7:0]  imm_seen;
	} scx_state_s;

endpackage : scx_pkg

// *** design/scx_wake.sv ***
// Purpose: Wake-condition evaluation for the two wait instructions
// Assumes: All inputs synchronous to clk
// Notes:   Pure combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module scx_wake (
	input  wire  scx_pkg::scx_wake_s src,
	input  wire  logic               for_irq,
	input  wire  logic               sev_on_pend,
	output logic                     wake
);
	always_comb begin
		if (for_irq) begin
			// Pending irq wakes even when masked
			wake = src.exc_take | src.dbg_request | src.irq_pending_any;
		end else begin
			wake = src.exc_take | (src.dbg_request & src.dbg_enabled) |
				src.ext_event;
			if (sev_on_pend && src.exc_pending_new) begin
				wake = 1'b1;
			end
		end
	end
endmodule // scx_wake
`default_nettype wire

// *** dv/scx_exec_props.sv ***
// Purpose: Concurrent checks on the execute unit ports
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into scx_exec by the statement after the module
`timescale 1ns/1ps
`default_nettype none
module scx_exec_props (
	input wire logic			clk,
	input wire logic			rst,
	input wire scx_pkg::scx_instr_s	instr,
	input wire logic			privileged,
	input wire logic			mem_outstanding,
	input wire logic			debugger_attached,
	input wire logic			call_prio_blocked,
	input wire scx_pkg::scx_wake_s	wake_src,
	input wire logic			busy,
	input wire logic			flush,
	input wire logic			event_out,
	input wire logic			call_req,
	input wire logic			fault_req,
	input wire logic			debug_halt,
	input wire logic			sleeping,
	input wire logic			irq_take,
	input wire logic			irq_mask,
	input wire logic [3:0]		flags,
	input wire scx_pkg::scx_wb_s	wb
);
	// ****
	// Helpers
	// ****
	scx_pkg::scx_op_e	op;
	logic			take;
	logic [3:0]		src_flags;
	assign op = instr.op;
	// Taken only when the unit is idle; held requests are not counted
	assign take = instr.valid && !busy;
	assign src_flags = instr.src[31:28];
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ****
	// Properties
	// ****
	a_evt_pulse: assert property (take && op == scx_pkg::SCX_OP_SEND_EVT
		|=> event_out ##1 !event_out) else $error("send event pulse wrong");
	a_barrier_flush: assert property (take &&
		op == scx_pkg::SCX_OP_INSTR_BAR && !mem_outstanding |=> flush)
		else $error("no flush after instruction barrier");
	a_mask_set: assert property (take && op == scx_pkg::SCX_OP_MASK_SET
		&& privileged |=> irq_mask) else $error("mask not set");
	a_mask_unpriv: assert property (take && !privileged &&
		(op == scx_pkg::SCX_OP_MASK_SET || op == scx_pkg::SCX_OP_MASK_CLEAR)
		|=> $stable(irq_mask)) else $error("unprivileged mask change");
	a_nmi_take: assert property (wake_src.nmi_pending |=> irq_take)
		else $error("nmi not taken");
	a_sync_stall: assert property (take &&
		op == scx_pkg::SCX_OP_SYNC_BAR && mem_outstanding |=> busy)
		else $error("sync barrier did not stall");
	a_wake_debug: assert property (sleeping && wake_src.dbg_request
		&& wake_src.dbg_enabled |=> !sleeping) else $error("debug no wake");
	a_read_zero: assert property (take && !privileged &&
		op == scx_pkg::SCX_OP_SREG_READ && instr.sreg_sel >= scx_pkg::SREG_MSP
		|=> wb.valid && wb.data == '0) else $error("unprivileged read leak");
	a_flags_write: assert property (take && instr.sreg_sel == 8'h0 &&
		op == scx_pkg::SCX_OP_SREG_WRITE |=> flags == $past(src_flags))
		else $error("flags not loaded");
	a_call_raise: assert property (take &&
		op == scx_pkg::SCX_OP_SUP_CALL && !call_prio_blocked
		|=> call_req && !fault_req) else $error("supervisor call lost");
	a_brk_halt: assert property (take && debugger_attached &&
		op == scx_pkg::SCX_OP_BREAKPOINT |=> debug_halt) else $error("no halt");
	c_sleep: cover property (sleeping ##1 !sleeping);
	c_drain: cover property (busy && !sleeping && mem_outstanding);
	c_fault: cover property (fault_req);
endmodule // scx_exec_props
bind scx_exec scx_exec_props u_props (.clk, .rst, .instr, .privileged,
	.mem_outstanding, .debugger_attached, .call_prio_blocked, .wake_src,
	.busy, .flush, .event_out, .call_req, .fault_req, .debug_halt, .sleeping,
	.irq_take, .irq_mask, .flags, .wb);
`default_nettype wire

// *** dv/scx_exec_tb.sv ***
// Purpose: Directed self-checking bench for the execute unit
// Assumes: Inputs change by non-blocking assignment at rising edges
// Notes:   Memory latency comes from the partner model parameter
`timescale 1ns/1ps
`default_nettype none
module scx_exec_tb;
	logic clk, rst, privileged, mem_issue, mem_outstanding;
	logic debugger_attached, brk_lockup_sel, call_prio_blocked;
	logic sev_on_pend, irq_request, busy, flush, event_out, call_req;
	logic fault_req, debug_halt, lockup, sleeping, irq_take, irq_mask;
	logic [3:0] flags;
	logic [1:0] control;
	logic [7:0] imm_seen;
	logic [31:0] ipsr_epsr;
	scx_pkg::scx_instr_s instr;
	scx_pkg::scx_wake_s wake_src;
	scx_pkg::scx_wb_s wb;
	int compares, miscompares, cycles;
	int drain_len;
	scx_exec u_dut (.clk, .rst, .instr, .privileged, .mem_outstanding,
		.debugger_attached, .brk_lockup_sel, .call_prio_blocked,
		.sev_on_pend, .irq_request, .wake_src, .ipsr_epsr, .busy, .flush,
		.event_out, .call_req, .fault_req, .debug_halt, .lockup, .sleeping,
		.irq_take, .irq_mask, .flags, .control, .imm_seen, .wb);
	scx_mem_model #(.LAT(6)) u_mem (.clk, .rst, .issue(mem_issue),
		.mem_outstanding);
	// ****
	// Tasks
	// ****
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Returns just after the take edge, when one-cycle answers stand
	task automatic issue(input scx_pkg::scx_op_e op, input logic [7:0] imm,
		input logic [7:0] sel, input logic [31:0] src);
		@(posedge clk);
		instr <= '{1'b1, op, imm, sel, src, 4'h3};
		@(posedge clk);
		instr.valid <= 1'b0;
		#1;
	endtask
	task automatic sleep_wake(input scx_pkg::scx_op_e op,
		input scx_pkg::scx_wake_s w);
		issue(op, 8'h0, 8'h0, 32'h0);
		check("sleeping", 32'(sleeping), 32'h1);
		@(posedge clk);
		wake_src <= w;
		@(posedge clk);
		wake_src <= '0;
		#1;
		check("woken", 32'(busy), 32'h0);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// A hang must still reach the verdict, so it counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			stop_test();
		end
	end
	// ****
	// Sequence
	// ****
	initial begin
		{rst, privileged, mem_issue, debugger_attached} = 4'hC;
		{brk_lockup_sel, call_prio_blocked, sev_on_pend, irq_request} = 4'h0;
		{compares, miscompares, cycles} = '0;
		instr = '0;
		wake_src = '0;
		ipsr_epsr = 32'h0000_0000;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		check("mask_rst", 32'(irq_mask), 32'h0);
		sleep_wake(scx_pkg::SCX_OP_WAIT_EVT, 7'h06);
		issue(scx_pkg::SCX_OP_SEND_EVT, 8'h0, 8'h0, 32'h0);
		check("event_out", 32'(event_out), 32'h1);
		issue(scx_pkg::SCX_OP_WAIT_EVT, 8'h0, 8'h0, 32'h0);
		check("wait_evt_set", 32'(busy), 32'h0);
		sev_on_pend <= 1'b1;
		sleep_wake(scx_pkg::SCX_OP_WAIT_EVT, 7'h08);
		sleep_wake(scx_pkg::SCX_OP_WAIT_IRQ, 7'h10);
		issue(scx_pkg::SCX_OP_MASK_SET, 8'h0, 8'h0, 32'h0);
		check("mask_set", 32'(irq_mask), 32'h1);
		irq_request <= 1'b1;
		@(posedge clk);
		#1;
		check("masked", 32'(irq_take), 32'h0);
		wake_src <= 7'h40;
		@(posedge clk);
		wake_src <= '0;
		#1;
		check("nmi", 32'(irq_take), 32'h1);
		privileged <= 1'b0;
		issue(scx_pkg::SCX_OP_MASK_CLEAR, 8'h0, 8'h0, 32'h0);
		check("unpriv", 32'(irq_mask), 32'h1);
		issue(scx_pkg::SCX_OP_SREG_WRITE, 8'h0, 8'h0, 32'hA000_0000);
		check("flags", 32'(flags), 32'hA);
		issue(scx_pkg::SCX_OP_SREG_WRITE, 8'h0, 8'h08, 32'h1234_5670);
		issue(scx_pkg::SCX_OP_SREG_READ, 8'h0, 8'h08, 32'h0);
		check("rd_zero", wb.data, 32'h0);
		privileged <= 1'b1;
		issue(scx_pkg::SCX_OP_MASK_CLEAR, 8'h0, 8'h0, 32'h0);
		check("mask_clr", 32'(irq_mask), 32'h0);
		issue(scx_pkg::SCX_OP_SREG_READ, 8'h0, 8'h08, 32'h0);
		check("rd_kept", wb.data, 32'h0);
		issue(scx_pkg::SCX_OP_SREG_WRITE, 8'h0, 8'h08, 32'h2000_1000);
		issue(scx_pkg::SCX_OP_SREG_READ, 8'h0, 8'h08, 32'h0);
		check("rd_data", wb.data, 32'h2000_1000);
		check("rd_dst", 32'(wb.dst), 32'h3);
		check("rd_valid", 32'(wb.valid), 32'h1);
		issue(scx_pkg::SCX_OP_SREG_WRITE, 8'h0, scx_pkg::SREG_CONTROL,
			32'h0000_0002);
		check("control", 32'(control), 32'h2);
		issue(scx_pkg::SCX_OP_IDLE, 8'h0, 8'h0, 32'h0);
		issue(scx_pkg::SCX_OP_MEM_BAR, 8'h0, 8'h0, 32'h0);
		check("flags_kept", 32'(flags), 32'hA);
		issue(scx_pkg::SCX_OP_INSTR_BAR, 8'h0, 8'h0, 32'h0);
		check("flush", 32'(flush), 32'h1);
		mem_issue <= 1'b1;
		@(posedge clk);
		mem_issue <= 1'b0;
		issue(scx_pkg::SCX_OP_SYNC_BAR, 8'h0, 8'h0, 32'h0);
		check("drain", 32'(busy), 32'h1);
		// Busy ends one cycle after the model drops its flag: LAT-1 cycles
		drain_len = 0;
		while (busy === 1'b1 && drain_len < 50) begin
			drain_len++;
			@(posedge clk);
			#1;
		end
		check("drain_len", 32'(drain_len), 32'h5);
		issue(scx_pkg::SCX_OP_SUP_CALL, 8'hFF, 8'h0, 32'h0);
		check("call", 32'(call_req), 32'h1);
		check("call_imm", 32'(imm_seen), 32'hFF);
		call_prio_blocked <= 1'b1;
		issue(scx_pkg::SCX_OP_SUP_CALL, 8'h0, 8'h0, 32'h0);
		check("call_fault", 32'(fault_req), 32'h1);
		debugger_attached <= 1'b0;
		issue(scx_pkg::SCX_OP_BREAKPOINT, 8'h5A, 8'h0, 32'h0);
		check("brk_fault", 32'(fault_req), 32'h1);
		brk_lockup_sel <= 1'b1;
		issue(scx_pkg::SCX_OP_BREAKPOINT, 8'h0, 8'h0, 32'h0);
		check("lockup", 32'(lockup), 32'h1);
		check("lockup_busy", 32'(busy), 32'h1);
		// Lockup is left only through reset
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		brk_lockup_sel <= 1'b0;
		#1;
		check("lockup_rst", 32'(lockup), 32'h0);
		debugger_attached <= 1'b1;
		issue(scx_pkg::SCX_OP_BREAKPOINT, 8'h3C, 8'h0, 32'h0);
		check("halt", 32'(debug_halt), 32'h1);
		check("brk_imm", 32'(imm_seen), 32'h3C);
		stop_test();
	end
endmodule // scx_exec_tb
`default_nettype wire

// *** dv/scx_mem_model.sv ***
// Purpose: Memory-system stand-in that keeps accesses outstanding
// Assumes: issue is a one-cycle pulse synchronous to clk
// Notes:   Latency is a parameter so drain length is known to the bench
`timescale 1ns/1ps
`default_nettype none
module scx_mem_model #(
	parameter int unsigned LAT = 6
) (
	input wire logic	clk,
	input wire logic	rst,
	input wire logic	issue,
	output logic		mem_outstanding
);
	// ****
	// Latency countdown
	// ****
	int unsigned cnt;
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= 0;
		end else if (issue) begin
			cnt <= LAT;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
	assign mem_outstanding = (cnt != 0);
endmodule // scx_mem_model
`default_nettype wire
